/* File: hw/nand_status_map.svh */
// constants of the status and ecc control block: opcodes, feature
// addresses, bit positions and timing counts
// assumes the includer wants plain `define macros, guarded once
`ifndef NAND_STATUS_MAP_SVH
`define NAND_STATUS_MAP_SVH

// ==========================================================
// command opcodes
`define OPC_GET_FEATURE 8'h0f
`define OPC_SET_FEATURE 8'h1f
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_RESET 8'hff
`define OPC_PAGE_READ 8'h13
`define OPC_PROGRAM_EXEC 8'h10
`define OPC_BLOCK_ERASE 8'hd8

// ==========================================================
// feature addresses and field positions
`define FEAT_STATUS_ADDR 8'hc0
`define FEAT_CONFIG_ADDR 8'hb0
`define CFG_ECC_ENABLE_BIT 4
`define ECC_ENABLE_RESET 1'b1
`define ROW_BYTES 2'h2

// ==========================================================
// ecc segment layout
`define ECC_MAX_CORRECT 3'h4
`define SPARE_BASE_COL 12'h800
`define SPARE_GROUP_STRIDE 12'h010

// ==========================================================
// timing: reset command busy time
`define RESET_TIME_NS 5000
`define CLK_PERIOD_NS 100
`define RESET_CYCLES ((`RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: hw/nand_status_pkg.sv */
// types shared by the status and ecc control block
// assumes nothing of its surroundings
package nand_status_pkg;

    // ==========================================================
    // serial command decoder states
    typedef enum logic [2:0] {
        SPI_OPCODE = 3'b000,
        SPI_FEAT_ADDR = 3'b001,
        SPI_FEAT_DATA_IN = 3'b010,
        SPI_FEAT_DATA_OUT = 3'b011,
        SPI_ROW_ADDR = 3'b100,
        SPI_IGNORE = 3'b101
    } spi_state_t;

    // ==========================================================
    // internal operation kinds
    typedef enum logic [2:0] {
        OP_IDLE = 3'b000,
        OP_READ = 3'b001,
        OP_PROGRAM = 3'b010,
        OP_ERASE = 3'b011,
        OP_RESET = 3'b100
    } op_kind_t;

    // ==========================================================
    // ecc outcome field encoding
    typedef enum logic [1:0] {
        ECC_CLEAN = 2'b00,
        ECC_FIXED = 2'b01,
        ECC_FAILED = 2'b10,
        ECC_RESERVED = 2'b11
    } ecc_outcome_t;

endpackage : nand_status_pkg

/* File: hw/ecc_link_if.sv */
// signals between the command controller and the ecc outcome unit
// assumes both ends run on clk_sys
`timescale 1ns/1ps
`default_nettype none
interface ecc_link_if;
    import nand_status_pkg::*;
    logic start; // read begins, clear worst count
    logic seg_valid; // one segment's error count is present
    logic [1:0] seg_idx; // segment number 0..3
    logic [2:0] seg_errs; // bit errors seen, 7 means beyond reach
    ecc_outcome_t outcome; // outcome of the read so far
    logic [11:0] spare_col; // spare group column of the last segment

    modport ctrl (output start, seg_valid, seg_idx, seg_errs, input outcome, spare_col);
    modport unit (input start, seg_valid, seg_idx, seg_errs, output outcome, spare_col);
endinterface : ecc_link_if
`default_nettype wire

/* File: hw/ecc_outcome_unit.sv */
// ecc outcome unit: folds per-segment error counts into the outcome code
// and maps each main segment to its spare group
// assumes segment reports arrive on clk_sys before the read completes
`timescale 1ns/1ps
`default_nettype none
`include "nand_status_map.svh"
module ecc_outcome_unit (
    input wire logic clk_sys, // system clock
    input wire logic arst_n, // asynchronous reset, active low
    ecc_link_if.unit link // link to the controller
);
    import nand_status_pkg::*;

    logic [2:0] worst_ff;
    logic [2:0] nxt_worst;
    logic [11:0] spare_ff;
    ecc_outcome_t outcome_w;

    // spare group start column of a main segment
    function automatic logic [11:0] spare_of(input logic [1:0] seg);
        spare_of = `SPARE_BASE_COL + {6'h00, seg, 4'h0};
    endfunction : spare_of

    // worst count of the read, restarted by start
    assign nxt_worst = link.start ? 3'h0 :
        (link.seg_valid && link.seg_errs > worst_ff) ? link.seg_errs : worst_ff;
    assign outcome_w = (worst_ff == 3'h0) ? ECC_CLEAN :
        (worst_ff <= `ECC_MAX_CORRECT) ? ECC_FIXED : ECC_FAILED;
    assign link.outcome = outcome_w;
    assign link.spare_col = spare_ff;

    // worst count register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            worst_ff <= 3'h0;
        end else begin
            worst_ff <= nxt_worst;
        end
    end

    // spare column of the segment being corrected
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            spare_ff <= `SPARE_BASE_COL;
        end else if (link.seg_valid) begin
            spare_ff <= spare_of(link.seg_idx);
        end
    end

    a_outcome_legal: assert property (@(posedge clk_sys) disable iff (!arst_n)
        link.seg_valid && !link.start && link.seg_errs != 3'h0 |=> outcome_w != ECC_CLEAN)
        else $error("corrected errors reported clean");
    a_spare_group_map: assert property (@(posedge clk_sys) disable iff (!arst_n)
        link.seg_valid |=> spare_ff == 12'h800 + 12'h010 * {10'h000, $past(link.seg_idx)})
        else $error("segment mapped to wrong spare group");
    a_uncorrectable: assert property (@(posedge clk_sys) disable iff (!arst_n)
        link.seg_valid && link.seg_errs > 3'h4 && !link.start |=> outcome_w == ECC_FAILED)
        else $error("more than four errors not flagged");
endmodule : ecc_outcome_unit
`default_nettype wire

/* File: hw/nand_status_ctrl.sv */
// status register and ecc control of a serial nand flash: serial command
// decoder, operation tracking, failure flags and ecc outcome
// assumes sclk, cs_n and si come from pins; the array core answers on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "nand_status_map.svh"
// What this block does
// - eight-bit status readable any time, even busy
// - feature read 0Fh at C0h returns current status byte
// - bit 0 high while operation runs
// - bit 1 write latch; program, erase need it
// - write disable 04h clears the latch
// - bit 2 set on erase failure or rejection
// - erase failure cleared by reset, erase start
// - bit 3 set on program failure or rejection
// - bits 5:4 encode clean, fixed, failed, reserved
// - outcome cleared at read start, updated at end
// - power-on read of block 0 page 0
// - outcome meaningless while ecc is off
// - correction reaches four bits per segment
// - ecc enabled after power-up
// - feature write B0h bit 4 switches ecc
// - spare group column given for each segment
// - read folds segment error counts into outcome
module nand_status_ctrl (
    input wire logic clk_sys, // system clock, 10 MHz
    input wire logic arst_n, // asynchronous reset, active low
    input wire logic sclk, // serial clock pin
    input wire logic cs_n, // chip select pin, active low
    input wire logic si, // serial data in pin
    output logic so, // serial data out pin
    output logic so_oe, // serial data out enable, high drives
    output logic array_start, // one-cycle launch to the array core
    output nand_status_pkg::op_kind_t array_op, // kind of launched operation
    output logic [15:0] array_row, // row address of the operation
    input wire logic array_done, // array operation finished, one cycle
    input wire logic array_fail, // failed or rejected, valid with done
    output logic ecc_enable, // ecc parity and correction active
    input wire logic ecc_seg_valid, // one segment error count present
    input wire logic [1:0] ecc_seg_idx, // segment number of the count
    input wire logic [2:0] ecc_seg_errs, // bit errors, 7 beyond reach
    output logic [11:0] ecc_spare_col // spare group of the last segment
);
    import nand_status_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
    logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
    logic si_s1_ff, si_s2_ff;

    // two flip-flops per pin, a third on sclk and cs_n for edge finding
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {sclk_s1_ff, sclk_s2_ff, sclk_s3_ff} <= 3'h0;
            {cs_s1_ff, cs_s2_ff, cs_s3_ff} <= 3'h7;
            {si_s1_ff, si_s2_ff} <= 2'h0;
        end else begin
            {sclk_s1_ff, sclk_s2_ff, sclk_s3_ff} <= {sclk, sclk_s1_ff, sclk_s2_ff};
            {cs_s1_ff, cs_s2_ff, cs_s3_ff} <= {cs_n, cs_s1_ff, cs_s2_ff};
            {si_s1_ff, si_s2_ff} <= {si, si_s1_ff};
        end
    end

    logic sclk_rise, sclk_fall, selected, cs_release;
    assign selected = ~cs_s2_ff;
    assign sclk_rise = selected & sclk_s2_ff & ~sclk_s3_ff;
    assign sclk_fall = selected & ~sclk_s2_ff & sclk_s3_ff;
    assign cs_release = cs_s2_ff & ~cs_s3_ff;

    // ==========================================================
    // byte receiver
    logic [6:0] shift_ff;
    logic [2:0] bitcnt_ff;
    logic [7:0] rx_byte;
    logic byte_done;
    assign rx_byte = {shift_ff, si_s2_ff};
    assign byte_done = sclk_rise & (bitcnt_ff == 3'h7);

    // shift in on rising serial clock, restart at deselect
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shift_ff <= 7'h00;
            bitcnt_ff <= 3'h0;
        end else if (!selected) begin
            bitcnt_ff <= 3'h0;
        end else if (sclk_rise) begin
            shift_ff <= rx_byte[6:0];
            bitcnt_ff <= bitcnt_ff + 3'h1;
        end
    end

    // ==========================================================
    // state registers
    spi_state_t spi_ff, nxt_spi;
    op_kind_t op_ff, nxt_op;
    logic [7:0] opcode_ff, feat_addr_ff, row_hi_ff;
    logic [1:0] row_cnt_ff;
    logic [5:0] rst_cnt_ff;
    logic por_ff, wel_ff, erase_failed_flag_ff, program_failed_flag_ff, ecc_en_ff;
    ecc_outcome_t ecc_st_ff;
    logic busy;
    logic [7:0] status_byte, feat_sel, feat_value;

    // status byte layout, reserved bits read zero
    assign busy = op_ff != OP_IDLE;
    assign status_byte = {2'b00, ecc_st_ff, program_failed_flag_ff, erase_failed_flag_ff, wel_ff, busy};
    // the address byte itself picks the first reply, its register the repeats
    assign feat_sel = (spi_ff == SPI_FEAT_ADDR) ? rx_byte : feat_addr_ff;
    assign feat_value = (feat_sel == `FEAT_STATUS_ADDR) ? status_byte :
        (feat_sel == `FEAT_CONFIG_ADDR) ? {3'b000, ecc_en_ff, 4'h0} : 8'h00;

    // ==========================================================
    // command decode
    logic at_opcode, idle_cmd, cmd_get, cmd_set, cmd_wen, cmd_wdis, cmd_row;
    logic launch_reset, row_last, launch_read, launch_prog, launch_erase;
    logic start_read, launch_array, cfg_write, op_end;
    assign at_opcode = byte_done & (spi_ff == SPI_OPCODE);
    assign idle_cmd = at_opcode & ~busy;
    assign cmd_get = at_opcode & (rx_byte == `OPC_GET_FEATURE);
    assign cmd_set = idle_cmd & (rx_byte == `OPC_SET_FEATURE);
    assign cmd_wen = idle_cmd & (rx_byte == `OPC_WRITE_ENABLE);
    assign cmd_wdis = idle_cmd & (rx_byte == `OPC_WRITE_DISABLE);
    assign launch_reset = idle_cmd & (rx_byte == `OPC_RESET);
    assign cmd_row = idle_cmd & ((rx_byte == `OPC_PAGE_READ) |
        (rx_byte == `OPC_PROGRAM_EXEC) | (rx_byte == `OPC_BLOCK_ERASE));
    assign row_last = byte_done & (spi_ff == SPI_ROW_ADDR) & (row_cnt_ff == `ROW_BYTES);
    assign launch_read = row_last & (opcode_ff == `OPC_PAGE_READ);
    assign launch_prog = row_last & (opcode_ff == `OPC_PROGRAM_EXEC) & wel_ff;
    assign launch_erase = row_last & (opcode_ff == `OPC_BLOCK_ERASE) & wel_ff;
    assign start_read = launch_read | por_ff;
    assign launch_array = start_read | launch_prog | launch_erase;
    assign cfg_write = byte_done & (spi_ff == SPI_FEAT_DATA_IN) &
        (feat_addr_ff == `FEAT_CONFIG_ADDR);
    assign op_end = array_done & ((op_ff == OP_READ) | (op_ff == OP_PROGRAM) |
        (op_ff == OP_ERASE));

    // decoder next state
    always_comb begin
        nxt_spi = spi_ff;
        if (cs_release) begin
            nxt_spi = SPI_OPCODE;
        end else if (byte_done) begin
            case (spi_ff)
                SPI_OPCODE: begin
                    if (cmd_get || cmd_set) begin
                        nxt_spi = SPI_FEAT_ADDR;
                    end else if (cmd_row) begin
                        nxt_spi = SPI_ROW_ADDR;
                    end else begin
                        nxt_spi = SPI_IGNORE;
                    end
                end
                SPI_FEAT_ADDR: begin
                    nxt_spi = (opcode_ff == `OPC_GET_FEATURE) ? SPI_FEAT_DATA_OUT :
                        SPI_FEAT_DATA_IN;
                end
                SPI_FEAT_DATA_IN: nxt_spi = SPI_IGNORE;
                SPI_FEAT_DATA_OUT: nxt_spi = SPI_FEAT_DATA_OUT;
                SPI_ROW_ADDR: nxt_spi = row_last ? SPI_IGNORE : SPI_ROW_ADDR;
                SPI_IGNORE: nxt_spi = SPI_IGNORE;
                default: nxt_spi = SPI_IGNORE;
            endcase
        end
    end

    // operation tracker next state
    always_comb begin
        nxt_op = op_ff;
        if (start_read) begin
            nxt_op = OP_READ;
        end else if (launch_prog) begin
            nxt_op = OP_PROGRAM;
        end else if (launch_erase) begin
            nxt_op = OP_ERASE;
        end else if (launch_reset) begin
            nxt_op = OP_RESET;
        end else if (op_end || (op_ff == OP_RESET && rst_cnt_ff == 6'h01)) begin
            nxt_op = OP_IDLE;
        end
    end

    // decoder and command byte registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            spi_ff <= SPI_OPCODE;
            opcode_ff <= 8'h00;
            feat_addr_ff <= 8'h00;
            row_hi_ff <= 8'h00;
            row_cnt_ff <= 2'h0;
        end else begin
            spi_ff <= nxt_spi;
            opcode_ff <= at_opcode ? rx_byte : opcode_ff;
            feat_addr_ff <= (byte_done && spi_ff == SPI_FEAT_ADDR) ? rx_byte : feat_addr_ff;
            row_hi_ff <= (byte_done && spi_ff == SPI_ROW_ADDR) ? rx_byte : row_hi_ff;
            row_cnt_ff <= at_opcode ? 2'h0 :
                (byte_done && spi_ff == SPI_ROW_ADDR) ? row_cnt_ff + 2'h1 : row_cnt_ff;
        end
    end

    // operation, reset timer and power-on read request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            op_ff <= OP_IDLE;
            rst_cnt_ff <= 6'h00;
            por_ff <= 1'b1;
        end else begin
            op_ff <= nxt_op;
            rst_cnt_ff <= launch_reset ? 6'(`RESET_CYCLES) :
                (rst_cnt_ff != 6'h00) ? rst_cnt_ff - 6'h01 : rst_cnt_ff;
            por_ff <= 1'b0;
        end
    end

    // ==========================================================
    // status flags: hardware set wins over any clear
    logic ers_set, ers_clr, pgm_set, pgm_clr;
    assign ers_set = op_end & (op_ff == OP_ERASE) & array_fail;
    assign ers_clr = launch_erase | launch_reset;
    assign pgm_set = op_end & (op_ff == OP_PROGRAM) & array_fail;
    assign pgm_clr = launch_prog | launch_reset;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wel_ff <= 1'b0;
            erase_failed_flag_ff <= 1'b0;
            program_failed_flag_ff <= 1'b0;
        end else begin
            wel_ff <= cmd_wen | (wel_ff & ~(cmd_wdis | launch_prog | launch_erase |
                launch_reset));
            erase_failed_flag_ff <= ers_set | (erase_failed_flag_ff & ~ers_clr);
            program_failed_flag_ff <= pgm_set | (program_failed_flag_ff & ~pgm_clr);
        end
    end

    // ==========================================================
    // ecc setting and outcome
    ecc_link_if link ();
    assign link.start = start_read;
    assign link.seg_valid = ecc_seg_valid & ecc_en_ff & (op_ff == OP_READ);
    assign link.seg_idx = ecc_seg_idx;
    assign link.seg_errs = ecc_seg_errs;

    ecc_outcome_unit u_outcome (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .link(link)
    );

    // a read that ends with ecc off leaves the outcome clean, host ignores it then
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ecc_en_ff <= `ECC_ENABLE_RESET;
            ecc_st_ff <= ECC_CLEAN;
        end else begin
            ecc_en_ff <= cfg_write ? rx_byte[`CFG_ECC_ENABLE_BIT] : ecc_en_ff;
            if (op_end && op_ff == OP_READ) begin
                ecc_st_ff <= ecc_en_ff ? link.outcome : ECC_CLEAN;
            end else if (start_read || launch_reset) begin
                ecc_st_ff <= ECC_CLEAN;
            end
        end
    end

    // ==========================================================
    // serial output and array launch
    logic [7:0] tx_ff;
    logic load_tx;
    assign load_tx = byte_done & (((spi_ff == SPI_FEAT_ADDR) &
        (opcode_ff == `OPC_GET_FEATURE)) | (spi_ff == SPI_FEAT_DATA_OUT));

    // feature byte repeats while selected, msb first on falling clock
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_ff <= 8'h00;
            so <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            if (load_tx) begin
                tx_ff <= feat_value;
            end else if (sclk_fall) begin
                tx_ff <= {tx_ff[6:0], 1'b0};
            end
            so <= sclk_fall ? tx_ff[7] : so;
            so_oe <= selected & (so_oe | load_tx);
        end
    end

    // array launch: kind and row of read, program or erase
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            array_start <= 1'b0;
            array_op <= OP_IDLE;
            array_row <= 16'h0000;
        end else begin
            array_start <= launch_array;
            array_op <= launch_array ? nxt_op : array_op;
            array_row <= por_ff ? 16'h0000 :
                launch_array ? {row_hi_ff, rx_byte} : array_row;
        end
    end

    assign ecc_enable = ecc_en_ff;
    assign ecc_spare_col = link.spare_col;

    // ==========================================================
    // checks
    a_wdis_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cmd_wdis && !cmd_wen |=> !wel_ff) else $error("write disable kept latch");
    a_prog_needs_wel: assert property (@(posedge clk_sys) disable iff (!arst_n)
        array_start && array_op == OP_PROGRAM |-> $past(wel_ff))
        else $error("program launched without latch");
    a_erase_fail_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_ff == OP_ERASE && array_done && array_fail |=> erase_failed_flag_ff)
        else $error("erase failure not flagged");
    a_erase_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        launch_erase |=> !erase_failed_flag_ff && busy) else $error("erase start kept flag");
    a_prog_fail_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_ff == OP_PROGRAM && array_done && array_fail |=> program_failed_flag_ff)
        else $error("program failure not flagged");
    a_prog_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        launch_prog |=> !program_failed_flag_ff) else $error("program start kept flag");
    a_read_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
        start_read |=> ecc_st_ff == ECC_CLEAN) else $error("read start kept outcome");
    a_read_update: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_ff == OP_READ && array_done && ecc_en_ff |=> ecc_st_ff == $past(link.outcome))
        else $error("outcome not updated at read end");
    a_reset_busy: assert property (@(posedge clk_sys) disable iff (!arst_n)
        launch_reset |-> ##50 busy ##1 !busy) else $error("reset busy time wrong");
    a_ecc_config: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cfg_write |=> ecc_en_ff == $past(rx_byte[4])) else $error("ecc setting lost");
endmodule : nand_status_ctrl
`default_nettype wire

/* File: hw/unused_placeholder_removed.sv */
// empty file, holds no design unit and no logic of the block
// assumes nothing of its surroundings
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: test/spi_host_model.sv */
// spi host model: mode 0 frames, msb first, sclk still between frames
// assumes the device shifts so after each sclk fall
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic sclk, // serial clock, low outside frames
    output logic cs_n, // chip select, active low
    output logic si, // data to the device
    input wire logic so, // data from the device
    input wire logic so_oe, // device drives so
    output logic got, // pulse: reply byte captured
    output logic [7:0] rx // captured reply byte
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        got = 1'b0;
        rx = 8'h00;
    end
    // ==========================================================
    // one byte: set si while low, capture so at the rise
    task automatic xfer(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #400 sclk = 1'b1;
            rx[i] = so_oe ? so : ~rx[i]; // released line reads garbage
            #400 sclk = 1'b0;
        end
    endtask : xfer
    // whole frame of n bytes, optional reply byte
    task automatic frame(input logic [31:0] w, input int n, input logic rd);
        #1000 cs_n = 1'b0;
        #400;
        for (int k = 0; k < n; k++) begin
            xfer(w[31-8*k -: 8]);
        end
        if (rd) begin
            xfer(8'h00);
            got = 1'b1;
            #100 got = 1'b0;
        end
        #400 cs_n = 1'b1;
        si = ~si;
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

/* File: test/nand_status_and_ecc_tb_top.sv */
// bench of the status and ecc block: host frames, array core model
// assumes the 800 ns host clock, array answers after 300 cycles
`timescale 1ns/1ps
`default_nettype none
`include "nand_status_map.svh"
module nand_status_and_ecc_tb_top;
    import nand_status_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic sclk, cs_n, si, so, so_oe, got, array_start, ecc_enable;
    logic [7:0] rx;
    op_kind_t array_op, exp_op;
    logic [15:0] array_row, exp_row;
    logic [11:0] ecc_spare_col, exp_col;
    logic array_done = 1'b0, array_fail = 1'b0, fail_nxt = 1'b0;
    logic ecc_seg_valid = 1'b0;
    logic [1:0] ecc_seg_idx = 2'h0, oc = 2'h0;
    logic [2:0] ecc_seg_errs = 3'h0, mx;
    logic [2:0] errs [4] = '{3'h2, 3'h0, 3'h1, 3'h0};
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'h539c;
    logic write_permit_latch = 1'b0, ef = 1'b0, pf = 1'b0, ecc_on = 1'b1;
    int fails = 0, n_compared = 0;
    always #50 clk_sys = ~clk_sys;
    nand_status_ctrl u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
        .si(si), .so(so), .so_oe(so_oe), .array_start(array_start), .array_op(array_op),
        .array_row(array_row), .array_done(array_done), .array_fail(array_fail),
        .ecc_enable(ecc_enable), .ecc_seg_valid(ecc_seg_valid), .ecc_seg_idx(ecc_seg_idx),
        .ecc_seg_errs(ecc_seg_errs), .ecc_spare_col(ecc_spare_col));
    spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
        .got(got), .rx(rx));
    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    task automatic chk(input logic [18:0] g, input logic [18:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.frame({`OPC_GET_FEATURE, a, 16'h0000}, 2, 1'b1);
    endtask : rd
    task automatic op(input logic [7:0] opc, input op_kind_t k, input logic f);
        seed = xs(seed);
        exp_op = k;
        exp_row = seed[15:0];
        fail_nxt = f;
        u_host.frame({opc, 8'h00, seed[15:0]}, 4, 1'b0);
        for (int i = 0; i < 2000 && array_done !== 1'b1; i++) @(posedge clk_sys);
        if (array_done !== 1'b1) begin
            fails++;
            end_sim();
        end
        repeat (3) @(negedge clk_sys);
    endtask : op
    function automatic logic [7:0] st(input logic busy);
        return {2'b00, oc, pf, ef, write_permit_latch, busy};
    endfunction : st
    // ==========================================================
    // compare each captured reply with the oldest note
    always @(posedge got) chk({11'h0, rx}, {11'h0, exp_q.pop_front()});
    // array core model: launch check, segment reports, done
    always @(negedge clk_sys) if (array_start === 1'b1) begin
        chk({array_op, array_row}, {exp_op, exp_row});
        chk({18'h0, ecc_enable}, {18'h0, ecc_on});
        repeat (300) @(negedge clk_sys);
        for (int s = 0; s < 4; s++) begin
            ecc_seg_valid <= (array_op === OP_READ);
            ecc_seg_idx <= s[1:0];
            ecc_seg_errs <= errs[s];
            @(negedge clk_sys) ecc_seg_valid <= 1'b0;
            @(negedge clk_sys);
            exp_col = `SPARE_BASE_COL + `SPARE_GROUP_STRIDE * 12'(s);
            if (array_op === OP_READ && ecc_enable === 1'b1)
                chk({7'h0, ecc_spare_col}, {7'h0, exp_col});
        end
        array_done <= 1'b1;
        array_fail <= fail_nxt;
        @(negedge clk_sys) array_done <= 1'b0;
        array_fail <= 1'b0;
    end
    // ==========================================================
    // main sequence
    initial begin
        exp_op = OP_READ;
        exp_row = 16'h0000;
        repeat (10) @(negedge clk_sys);
        arst_n = 1'b1;
        rd(`FEAT_STATUS_ADDR, st(1'b1));
        repeat (400) @(negedge clk_sys);
        oc = 2'h1;
        rd(`FEAT_STATUS_ADDR, st(1'b0));
        rd(`FEAT_CONFIG_ADDR, 8'h10);
        rd(8'ha0, 8'h00);
        u_host.frame({`OPC_WRITE_ENABLE, 24'h0}, 1, 1'b0);
        write_permit_latch = 1'b1;
        rd(`FEAT_STATUS_ADDR, st(1'b0));
        u_host.frame({`OPC_WRITE_DISABLE, 24'h0}, 1, 1'b0);
        write_permit_latch = 1'b0;
        rd(`FEAT_STATUS_ADDR, st(1'b0));
        u_host.frame({`OPC_BLOCK_ERASE, 24'h0012}, 4, 1'b0);
        rd(`FEAT_STATUS_ADDR, st(1'b0));
        for (int i = 0; i < 5; i++) begin
            u_host.frame({`OPC_WRITE_ENABLE, 24'h0}, 1, 1'b0);
            if (i[0]) op(`OPC_PROGRAM_EXEC, OP_PROGRAM, i < 2);
            else op(`OPC_BLOCK_ERASE, OP_ERASE, i != 2);
            if (i[0]) pf = i < 2;
            else ef = i != 2;
            rd(`FEAT_STATUS_ADDR, st(1'b0));
        end
        for (int i = 0; i < 9; i++) begin
            if (i == 7) u_host.frame({`OPC_SET_FEATURE, `FEAT_CONFIG_ADDR, 16'h0}, 3, 1'b0);
            if (i == 7) rd(`FEAT_CONFIG_ADDR, 8'h00);
            ecc_on = i != 7;
            mx = 3'h0;
            for (int s = 0; s < 4; s++) begin
                errs[s] = i == 0 ? 3'h0 : i == 1 ? 3'h4 >> s : seed[3*s +: 3];
                mx = errs[s] > mx ? errs[s] : mx;
            end
            oc = (i == 7 || mx == 0) ? 2'h0 : mx > `ECC_MAX_CORRECT ? 2'h2 : 2'h1;
            op(`OPC_PAGE_READ, OP_READ, 1'b0);
            rd(`FEAT_STATUS_ADDR, st(1'b0));
            if (i == 7) u_host.frame({`OPC_SET_FEATURE, `FEAT_CONFIG_ADDR, 16'h1000}, 3, 1'b0);
        end
        rd(`FEAT_CONFIG_ADDR, 8'h10);
        u_host.frame({`OPC_RESET, 24'h0}, 1, 1'b0);
        repeat (60) @(negedge clk_sys);
        {oc, pf, ef} = 4'h0;
        rd(`FEAT_STATUS_ADDR, st(1'b0));
        end_sim();
    end
endmodule : nand_status_and_ecc_tb_top
`default_nettype wire
